/* hw/multimode_timer.sv */
// Multimode 16-bit timer with prescaler, output and input pins.
// Assumes one 100 MHz clock, a byte-wide register port, input pin async.
//
// Operation
// - One-shot: output inverted one cycle at reload
// - One-shot counts prescaled clock only
// - Continuous: reload interrupts, restart at 0001H
// - Continuous: output toggles at each reload
// - Continuous: start count affects first pass only
// - Counter: count input edges, polarity selects
// - Counter: prescaler bypassed, one edge per step
// - Counter: reload interrupts, restart at 0001H
// - Capture-restart: selected edge copies count
// - Capture: interrupt, set flag, restart count
// - Reload without capture: interrupt, clear flag
// - Interrupt source selectable; default both events
// - Mode uses extension bit for capture-restart
// - Compare: interrupt on match, no reset
// - Compare: output toggles on each match
// - Compare: counter wraps FFFFH to 0000H
// - Output and complement pin; complement becomes input
module multimode_timer
	import timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input timer_pkg::reg_req_t req,
	output timer_pkg::pins_t pins,
	input wire logic timer_input_pin,
	output logic [7:0] rdata,
	output logic irq
);
	import timer_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	logic [7:0] ctl0_q; // Main control
	logic mode_extension_bit_q; // Extra mode bit
	logic [1:0] interrupt_source_select_q; // Interrupt filter
	logic out_en_q; // Output alternate function enable
	logic capture_event_flag_q; // Last interrupt was a capture
	logic [15:0] count_q; // Timer count
	logic [15:0] reload_q; // Reload / compare value
	logic [15:0] capture_q; // Capture value
	logic [6:0] presc_q; // Prescale divider
	logic [2:0] sync_q; // Input synchroniser and edge history
	logic out_q; // Output level
	logic pulse_q; // One-shot pulse active
	logic [7:0] rdata_q; // Read data
	logic irq_q; // Interrupt pulse

	logic enabled;
	logic pol;
	mode_t mode;
	logic tick; // Prescaled step
	logic edge_hit; // Qualified input edge
	logic step; // Counter advances this cycle
	logic at_reload; // Count meets reload value
	logic reload_ev; // Reload/compare event
	logic capture_ev; // Capture event

	assign enabled = ctl0_q[CTL0_EN];
	assign pol = ctl0_q[CTL0_POL];

	// Mode decode with the extension bit
	function automatic mode_t decode_mode(input logic hi, input logic [2:0] lo);
		mode_t m;
		m = MODE_ONE_SHOT;
		case ({hi, lo})
			4'h0: m = MODE_ONE_SHOT;
			4'h1: m = MODE_CONTINUOUS;
			4'h2: m = MODE_COUNTER;
			4'h3: m = MODE_COMPARE;
			4'h8: m = MODE_CAPTURE_RESTART;
			default: m = MODE_ONE_SHOT;
		endcase
		return m;
	endfunction

	assign mode = decode_mode(mode_extension_bit_q, ctl0_q[CTL0_MODE_LSB +: 3]);

	// ****************************************
	// Prescaler and input edge
	// ****************************************

	// Prescaler runs only while enabled so every pass starts aligned
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			presc_q <= 7'h00;
		end else if (!enabled || tick) begin
			presc_q <= 7'h00;
		end else begin
			presc_q <= presc_q + 7'h01;
		end
	end

	// Divide by 2^exponent; exponent 0 steps every cycle
	assign tick = enabled && (presc_q == ((7'h01 << ctl0_q[CTL0_PRES_LSB +: 3]) - 7'h01));

	// Two flops before use, third keeps history for edges
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sync_q <= 3'b000;
		end else begin
			sync_q <= {sync_q[1:0], timer_input_pin};
		end
	end

	// Polarity picks rising (1) or falling (0); synced bits only
	assign edge_hit = pol ? (sync_q[1] && !sync_q[2]) : (!sync_q[1] && sync_q[2]);

	// Counter mode bypasses the prescaler; others use it, never the pin
	assign step = enabled && ((mode == MODE_COUNTER) ? edge_hit : tick);
	assign at_reload = (count_q == reload_q);
	assign capture_ev = enabled && (mode == MODE_CAPTURE_RESTART) && edge_hit;
	assign reload_ev = step && at_reload && !capture_ev;

	// ****************************************
	// Counter
	// ****************************************

	// Capture has priority over a reload falling in the same cycle
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			count_q <= CNT_RESET;
		end else if (req.wr && req.addr == OFF_CNT_HI) begin
			count_q[15:8] <= req.wdata;
		end else if (req.wr && req.addr == OFF_CNT_LO) begin
			count_q[7:0] <= req.wdata;
		end else if (capture_ev) begin
			count_q <= CNT_RESTART;
		end else if (step) begin
			case (mode)
				MODE_COMPARE: begin
					count_q <= count_q + 16'h0001;
				end
				MODE_ONE_SHOT: begin
					// Stops here; enable drops in the same edge
					count_q <= at_reload ? CNT_RESTART : count_q + 16'h0001;
				end
				default: begin
					// Written start only shapes the first pass
					count_q <= at_reload ? CNT_RESTART : count_q + 16'h0001;
				end
			endcase
		end
	end

	// ****************************************
	// Control registers
	// ****************************************

	// One-shot hardware clear of enable yields only to reset; it beats a CTL0 write
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ctl0_q <= CTL0_RESET;
		end else if (reload_ev && mode == MODE_ONE_SHOT) begin
			ctl0_q[CTL0_EN] <= 1'b0;
		end else if (req.wr && req.addr == OFF_CTL0) begin
			ctl0_q <= req.wdata;
		end
	end

	// Second control: mode bit, interrupt filter, output enable
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mode_extension_bit_q <= CTL1_RESET[CTL1_MODEHI];
			interrupt_source_select_q <= CTL1_RESET[CTL1_ISRC_LSB +: 2];
			out_en_q <= CTL1_RESET[CTL1_OUTEN];
		end else if (req.wr && req.addr == OFF_CTL1) begin
			mode_extension_bit_q <= req.wdata[CTL1_MODEHI];
			interrupt_source_select_q <= req.wdata[CTL1_ISRC_LSB +: 2];
			out_en_q <= req.wdata[CTL1_OUTEN];
		end
	end

	// Flag tells software which event caused the interrupt
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			capture_event_flag_q <= 1'b0;
		end else if (capture_ev) begin
			capture_event_flag_q <= 1'b1;
		end else if (reload_ev && mode == MODE_CAPTURE_RESTART) begin
			capture_event_flag_q <= 1'b0;
		end
	end

	// Reload value
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			reload_q <= RLD_RESET;
		end else if (req.wr && req.addr == OFF_RLD_HI) begin
			reload_q[15:8] <= req.wdata;
		end else if (req.wr && req.addr == OFF_RLD_LO) begin
			reload_q[7:0] <= req.wdata;
		end
	end

	// Capture register; a capture beats a software write
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			capture_q <= CNT_RESET;
		end else if (capture_ev) begin
			capture_q <= count_q;
		end else if (req.wr && req.addr == OFF_CAP_HI) begin
			capture_q[15:8] <= req.wdata;
		end else if (req.wr && req.addr == OFF_CAP_LO) begin
			capture_q[7:0] <= req.wdata;
		end
	end

	// ****************************************
	// Interrupt and output pin
	// ****************************************

	// Filter by source; default passes both
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			case (interrupt_source_select_q)
				ISRC_CAPTURE: irq_q <= capture_ev;
				ISRC_RELOAD: irq_q <= reload_ev;
				default: irq_q <= capture_ev || reload_ev;
			endcase
		end
	end

	// One-shot pulse lasts a single cycle then restores the level
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= reload_ev && out_en_q && (mode == MODE_ONE_SHOT);
		end
	end

	// Level follows polarity while idle; toggles in toggling modes
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			out_q <= 1'b0;
		end else if (!out_en_q) begin
			out_q <= 1'b0;
		end else if (!enabled && !pulse_q) begin
			out_q <= pol; // Initial level set while stopped
		end else if (mode == MODE_ONE_SHOT) begin
			out_q <= (reload_ev && !pulse_q) ? !pol : pol;
		end else if (reload_ev && mode != MODE_CAPTURE_RESTART) begin
			out_q <= !out_q;
		end
	end

	// Complement pin is the input in counter and capture modes
	assign pins.out = out_q;
	assign pins.out_n = !out_q;
	assign pins.out_n_en = out_en_q && (mode != MODE_COUNTER) && (mode != MODE_CAPTURE_RESTART);

	// ****************************************
	// Read port
	// ****************************************

	// Data valid the cycle after the read strobe
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rdata_q <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				OFF_CTL0: rdata_q <= ctl0_q;
				OFF_CTL1: rdata_q <= {mode_extension_bit_q, interrupt_source_select_q,
					capture_event_flag_q, 3'b000, out_en_q};
				OFF_CNT_HI: rdata_q <= count_q[15:8];
				OFF_CNT_LO: rdata_q <= count_q[7:0];
				OFF_RLD_HI: rdata_q <= reload_q[15:8];
				OFF_RLD_LO: rdata_q <= reload_q[7:0];
				OFF_CAP_HI: rdata_q <= capture_q[15:8];
				OFF_CAP_LO: rdata_q <= capture_q[7:0];
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;

endmodule

/* hw/timer_pkg.sv */
// Package for the multimode 16-bit timer: register map, fields, modes.
// Assumes a single system clock and a plain strobe register port.
package timer_pkg;

	// ****************************************
	// Register offsets (byte-wide registers)
	// ****************************************
	localparam logic [3:0] OFF_CTL0 = 4'h0; // Main control
	localparam logic [3:0] OFF_CTL1 = 4'h1; // Second control
	localparam logic [3:0] OFF_CNT_HI = 4'h2; // Count high
	localparam logic [3:0] OFF_CNT_LO = 4'h3; // Count low
	localparam logic [3:0] OFF_RLD_HI = 4'h4; // Reload high
	localparam logic [3:0] OFF_RLD_LO = 4'h5; // Reload low
	localparam logic [3:0] OFF_CAP_HI = 4'h6; // Capture high
	localparam logic [3:0] OFF_CAP_LO = 4'h7; // Capture low

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTL0_EN = 7; // Timer enable
	localparam int CTL0_POL = 6; // Polarity select
	localparam int CTL0_PRES_LSB = 3; // Prescale exponent [5:3]
	localparam int CTL0_MODE_LSB = 0; // Mode low bits [2:0]
	localparam int CTL1_MODEHI = 7; // Mode extension bit
	localparam int CTL1_ISRC_LSB = 5; // Interrupt source select [6:5]
	localparam int CTL1_CAPFLAG = 4; // Capture event flag (read only)
	localparam int CTL1_OUTEN = 0; // Output alternate function enable

	// ****************************************
	// Reset values and constants
	// ****************************************
	localparam logic [7:0] CTL0_RESET = 8'h00;
	localparam logic [7:0] CTL1_RESET = 8'h00;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] RLD_RESET = 16'hFFFF;
	localparam logic [15:0] CNT_RESTART = 16'h0001;

	// Decoded mode: {extension bit, mode field}
	typedef enum logic [3:0] {
		MODE_ONE_SHOT = 4'h0,
		MODE_CONTINUOUS = 4'h1,
		MODE_COUNTER = 4'h2,
		MODE_COMPARE = 4'h3,
		MODE_CAPTURE_RESTART = 4'h8
	} mode_t;

	// Interrupt source select codes
	localparam logic [1:0] ISRC_BOTH = 2'h0;
	localparam logic [1:0] ISRC_CAPTURE = 2'h1;
	localparam logic [1:0] ISRC_RELOAD = 2'h2;

	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Timer pins toward the port logic
	typedef struct packed {
		logic out; // Timer output pin level
		logic out_n; // Complement output level
		logic out_n_en; // Complement pin carries output (not input)
	} pins_t;

endpackage

/* tb/input_source.sv */
// Signal source model on the timer input pin.
// Assumes it shares the bench clock.
module input_source (
	input wire logic clk_sys,
	output logic level
);
	timeunit 1ns;
	timeprecision 1ps;
	initial level = 1'b0;
	// Each level held 4..7 cycles, so never faster than a quarter clock
	task automatic toggle(input int k);
		repeat (k) begin
			repeat (4 + $urandom_range(0, 3)) @(posedge clk_sys);
			level <= ~level;
		end
	endtask
endmodule

/* tb/multimode_timer_test.sv */
// Self-checking bench for the multimode timer.
// Assumes timer_pkg, the bound checker and the input source model.
module multimode_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import timer_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	reg_req_t req = '0;
	pins_t pins;
	logic pin_lvl;
	logic [7:0] rdata;
	logic irq;
	int fail_count = 0;
	int comparisons = 0;
	logic [7:0] rd_exp[$]; // Expected read data
	int gap_exp[$]; // Expected cycles between interrupts
	logic rd_pend = 1'b0;
	logic armed = 1'b0;
	int gap = 0;
	int n;
	multimode_timer multimode_timer_i (.clk_sys(clk_sys), .reset(reset), .req(req),
		.pins(pins), .timer_input_pin(pin_lvl), .rdata(rdata), .irq(irq));
	input_source input_source_i (.clk_sys(clk_sys), .level(pin_lvl));
	initial forever #5 clk_sys = ~clk_sys;
	// ******************
	// Compare and monitor
	// ******************
	task automatic cmp_data(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_gap(input int e, input int g);
		comparisons++;
		if (g != e) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Read data one cycle after the strobe; irq spacing in cycles
	always @(posedge clk_sys) begin
		if (rd_pend && rd_exp.size() > 0) cmp_data(rd_exp.pop_front(), rdata);
		rd_pend = req.rd;
		if (irq === 1'b1) begin
			if (armed && gap_exp.size() > 0) cmp_gap(gap_exp.pop_front(), gap);
			gap = 1;
			armed = 1'b1;
		end else gap++;
	end
	// ******************
	// Bus tasks
	// ******************
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{a, d, 1'b1, 1'b0};
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[15:8]);
		wr(a + 4'h1, v[7:0]);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		rd_exp.push_back(e);
		@(posedge clk_sys);
		req <= '{a, 8'h00, 1'b0, 1'b1};
	endtask
	task automatic idle(input int c);
		@(posedge clk_sys);
		req <= '0;
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic wait_irq(input int lim);
		int i;
		i = 0;
		idle(0);
		do begin
			@(posedge clk_sys);
			#1;
			i++;
		end while (irq !== 1'b1 && i < lim);
		if (i >= lim) fail_count++;
	endtask
	task automatic conclude();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog, well past the expected run
	initial begin
		#1_000_000;
		fail_count++;
		conclude();
	end
	// ******************
	// Scenarios
	// ******************
	initial begin
		void'($urandom(90477));
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rd(OFF_CTL0, CTL0_RESET);
		rd(OFF_RLD_HI, RLD_RESET[15:8]);
		rd(4'hF, 8'h00);
		// Continuous, prescale 2, even start count
		wr16(OFF_CNT_HI, 16'h0002);
		wr16(OFF_RLD_HI, 16'h0005);
		wr(OFF_CTL1, 8'h01);
		armed = 1'b0;
		gap_exp = {10, 10};
		wr(OFF_CTL0, 8'h89);
		repeat (3) wait_irq(100);
		wr(OFF_CTL0, 8'h00);
		// Compare across the wrap
		wr16(OFF_CNT_HI, 16'hFFFE);
		wr16(OFF_RLD_HI, 16'h0003);
		armed = 1'b0;
		gap_exp = {65536};
		wr(OFF_CTL0, 8'h83);
		repeat (2) wait_irq(70000);
		wr(OFF_CTL0, 8'h00);
		// Counter, both edges, prescale set but bypassed; reload kept out of reach
		wr16(OFF_RLD_HI, 16'hFFFF);
		for (int p = 0; p < 2; p++) begin
			n = $urandom_range(1, 6);
			wr16(OFF_CNT_HI, 16'h0001);
			wr(OFF_CTL0, {1'b1, p[0], 6'h3A});
			idle(0);
			input_source_i.toggle(2 * n + 1);
			idle(8);
			rd(OFF_CNT_LO, 8'(1 + n + p));
			wr(OFF_CTL0, 8'h00);
			idle(0);
			input_source_i.toggle(1);
		end
		// Capture-restart, then reload without capture
		wr(OFF_CTL1, 8'h80);
		wr16(OFF_CNT_HI, 16'h0001);
		wr16(OFF_RLD_HI, 16'h0200);
		wr16(OFF_CAP_HI, 16'h0000);
		armed = 1'b0;
		gap_exp = {512};
		// Pin idles low, so capture on the rising edge
		wr(OFF_CTL0, 8'hC0);
		idle(0);
		input_source_i.toggle(1);
		wait_irq(50);
		rd(OFF_CTL1, 8'h90);
		wait_irq(600);
		rd(OFF_CTL1, 8'h80);
		wr(OFF_CTL0, 8'h00);
		// One-shot stops itself
		wr(OFF_CTL1, 8'h01);
		wr16(OFF_CNT_HI, 16'h0001);
		wr16(OFF_RLD_HI, 16'h0004);
		wr(OFF_CTL0, 8'hC0);
		wr(OFF_CTL0, 8'h80);
		wait_irq(20);
		idle(4);
		rd(OFF_CTL0, 8'h00);
		rd(OFF_CNT_LO, 8'h01);
		idle(2);
		conclude();
	end
endmodule

/* tb/timer_chk.sv */
// Port checker for the multimode timer.
// Assumes timer_pkg and a single clk_sys domain.
module timer_chk
	import timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input timer_pkg::reg_req_t req,
	input timer_pkg::pins_t pins,
	input wire logic timer_input_pin,
	input wire logic [7:0] rdata,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ******************
	// Control shadow
	// ******************
	logic [7:0] c0_q; // Last main control write
	logic [7:0] c1_q; // Last second control write
	logic [1:0] quiet_q; // Cycles since a control write
	wire quiet = quiet_q == 2'h3;
	wire [3:0] mode = {c1_q[CTL1_MODEHI], c0_q[2:0]};
	// Enable clear by hardware is unseen; rely on mode bits
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			c0_q <= 8'h00;
			c1_q <= 8'h00;
		end else if (req.wr && req.addr == OFF_CTL0) begin
			c0_q <= req.wdata;
		end else if (req.wr && req.addr == OFF_CTL1) begin
			c1_q <= req.wdata;
		end
	end
	// Settling window after control writes
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			quiet_q <= 2'h0;
		end else if (req.wr && req.addr[3:1] == 3'h0) begin
			quiet_q <= 2'h0;
		end else if (!quiet) begin
			quiet_q <= quiet_q + 2'h1;
		end
	end
	// ******************
	// Assertions
	// ******************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	sequence back_to_pol;
		##1 pins.out == c0_q[CTL0_POL];
	endsequence
	irq_single_a: assert property (irq |=> !irq) else $error("irq wider than a cycle");
	rdata_idle_a: assert property (!req.rd |=> rdata == 8'h00) else $error("rdata not idle");
	unmapped_read_a: assert property (req.rd && req.addr[3] |=> rdata == 8'h00)
		else $error("unmapped read nonzero");
	out_pair_a: assert property (pins.out_n == !pins.out) else $error("bad complement");
	input_pin_a: assert property (quiet && (mode == MODE_COUNTER ||
		mode == MODE_CAPTURE_RESTART) |-> !pins.out_n_en) else $error("input pin driven");
	out_off_a: assert property (quiet && !c1_q[CTL1_OUTEN] |-> !pins.out)
		else $error("output not forced low");
	toggle_irq_a: assert property (quiet && c1_q == 8'h01 && c0_q[CTL0_EN] &&
		(mode == MODE_CONTINUOUS || mode == MODE_COMPARE) |-> $changed(pins.out) == irq)
		else $error("toggle not tied to irq");
	one_shot_a: assert property (quiet && mode == MODE_ONE_SHOT && c1_q[CTL1_OUTEN] &&
		pins.out != c0_q[CTL0_POL] |-> back_to_pol) else $error("pulse not one cycle");
endmodule
bind multimode_timer timer_chk timer_chk_i (
	.clk_sys(clk_sys),
	.reset(reset),
	.req(req),
	.pins(pins),
	.timer_input_pin(timer_input_pin),
	.rdata(rdata),
	.irq(irq)
);
